// File: rtl/pis_pkg.sv
// Constants, register map and state encoding of the interrupt sequencer
package pis_pkg;

  // Source flag positions in the flag and enable registers
  localparam int FLAG_N     = 18;
  localparam int F_KEYPIN   = 0;
  localparam int F_CMATCH   = 1;
  localparam int F_TICK     = 2;
  localparam int F_LFIDENT  = 3;
  localparam int F_LFCARR   = 4;
  localparam int F_LFERR    = 5;
  localparam int F_LFBYTE   = 6;
  localparam int F_CONV     = 7;
  localparam int F_RSENT    = 8;
  localparam int F_RERR     = 9;
  localparam int F_RLOW     = 10;
  localparam int F_SENSOR   = 11;
  localparam int F_LAST     = 17;
  localparam int SINGLE_N   = 7;

  // Priorities of the named sources; P_SENSOR heads the plain per-flag run
  localparam int P_KEYPIN   = 15;
  localparam int P_CMATCH   = 14;
  localparam int P_SPARE    = 13;
  localparam int P_TICK     = 12;
  localparam int P_LOWFREQ  = 11;
  localparam int P_CONV     = 10;
  localparam int P_RADIO    = 9;
  localparam int P_SENSOR   = 8;
  localparam logic [3:0] P_SOFT  = 4'h1;
  localparam logic [3:0] P_RESET = 4'h0;

  // Vector table base: pair for priority 15 sits lowest
  localparam logic [15:0] VEC_BASE = 16'hFFE0;

  // Condition code register
  localparam int         CCR_I_BIT = 3;
  localparam logic [7:0] CCR_RESET = 8'h08;

  // APB register byte offsets
  localparam int         APB_AW    = 8;
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_EN    = 8'h04;
  localparam logic [7:0] OFS_CCR   = 8'h08;
  localparam logic [7:0] OFS_SP    = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;

  // Radio flags share the enable at F_RSENT, so their own bits read zero
  localparam logic [FLAG_N-1:0] EN_MASK = 18'h3_F9FF;

  // Byte counts of each sequence step, as last index
  localparam logic [2:0] PUSH_LAST = 3'h4;
  localparam logic [2:0] VEC_LAST  = 3'h1;
  localparam logic [2:0] FILL_LAST = 3'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PUSH = 3'b001,
    S_VECT = 3'b010,
    S_FILL = 3'b011,
    S_POP  = 3'b100
  } pis_state_t;

  // Memory access phases: address out, bus cycle, read data back
  localparam logic [1:0] PH_SET  = 2'h0;
  localparam logic [1:0] PH_BUS  = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

endpackage

// File: rtl/pis_sequencer.sv
// Interrupt flag collection, priority select and CPU entry/return sequencing
//
// How it works
// RQ1 - Events set flags; software only clears
// RQ2 - Request needs enable; CPU needs mask clear
// RQ3 - Reset leaves global mask set
// RQ4 - Entry starts only at instruction boundary
// RQ5 - Interrupt entry reuses soft trap sequence
// RQ6 - Push PC low, PC high, X, A, CONDITION_CODE_REG
// RQ7 - Stack pointer decrements after each push
// RQ8 - Stacked PC is next instruction address
// RQ9 - Entry sets the global mask bit
// RQ10 - Vector chosen when fetched, highest pending
// RQ11 - Fill queue with three routine bytes
// RQ12 - Return pops CONDITION_CODE_REG, A, X, PC
// RQ13 - Return refills queue from restored PC
// RQ14 - Index high byte never stacked by hardware
// RQ15 - Highest priority served first after unmask
// RQ16 - Vector high byte at lower address
// RQ17 - Priority rises toward higher vector addresses
// RQ18 - Priority 13 pair never requested
// RQ19 - Tick only outside stop; conversion at 10
// RQ20 - Four low-frequency flags share priority 11
// RQ21 - Three radio flags, one enable, priority 9
// RQ22 - Any pending request wakes from stop
// RQ23 - Service routine clears its flag first
// RQ24 - Priorities 8 to 0 fixed as listed
// RQ25 - Flag AND enable feeds priority encoder
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pis_sequencer
  import pis_pkg::*;
#(
  parameter logic [15:0] SP_INIT = 16'h00FF
) (
  input  wire  logic               core_clk,
  input  wire  logic               rstn,
  input  wire  logic               psel,
  input  wire  logic               penable,
  input  wire  logic               pwrite,
  input  wire  logic [APB_AW-1:0]  paddr,
  input  wire  logic [31:0]        pwdata,
  output logic       [31:0]        prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire  logic [FLAG_N-1:0]  src_event,
  input  wire  logic               stop_mode,
  input  wire  logic               instr_boundary,
  input  wire  logic               soft_trap,
  input  wire  logic               return_trap,
  input  wire  logic [15:0]        cpu_next_pc,
  input  wire  logic [7:0]         cpu_acc,
  input  wire  logic [7:0]         cpu_x,
  output logic                     mem_req,
  output logic                     mem_we,
  output logic       [15:0]        mem_addr,
  output logic       [7:0]         mem_wdata,
  input  wire  logic [7:0]         mem_rdata,
  output logic                     seq_busy,
  output logic                     seq_done,
  output logic       [7:0]         queue_byte,
  output logic                     queue_valid,
  output logic       [15:0]        resume_pc,
  output logic       [7:0]         restored_acc,
  output logic       [7:0]         restored_x,
  output logic       [7:0]         condition_code_reg,
  output logic                     irq_request,
  output logic                     wake_request
);

  // The stack frame must fit above address zero
  if (SP_INIT < 16'h0005) begin : g_sp_check
    $error("SP_INIT too small for a five byte frame");
  end

  // Lowest set priority number wins
  function automatic logic [3:0] prio_pick(input logic [15:0] grp);
    logic [3:0] p;
    p = P_RESET;
    for (int i = 15; i >= 0; i--) begin
      if (grp[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  // Address of the high byte of a vector pair
  function automatic logic [15:0] vec_addr(input logic [3:0] p);
    return {VEC_BASE[15:5], ~p, 1'b0};
  endfunction

  function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  pis_state_t         state_reg;
  logic [2:0]         cnt_reg;
  logic [1:0]         ph_reg;
  logic               hw_entry_reg;
  logic [3:0]         entry_prio_reg;
  logic [3:0]         vec_prio_reg;
  logic [15:0]        pc_reg;
  logic [15:0]        sp_reg;
  logic [7:0]         acc_reg;
  logic [7:0]         x_reg;
  logic [7:0]         ccr_reg;
  logic [FLAG_N-1:0]  flag_reg;
  logic [FLAG_N-1:0]  flag_next;
  logic [FLAG_N-1:0]  en_reg;
  logic [FLAG_N-1:0]  en_next;
  logic [FLAG_N-1:0]  en_eff;
  logic [FLAG_N-1:0]  flag_req;
  logic [15:0]        grp_req;
  logic               mem_req_reg;
  logic               mem_we_reg;
  logic [15:0]        mem_addr_reg;
  logic [7:0]         mem_wdata_reg;
  logic               busy_reg;
  logic               done_reg;
  logic [7:0]         qbyte_reg;
  logic               qvalid_reg;
  logic               irq_reg;
  logic               wake_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  // APB decode; zero wait states, one access cycle
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready_reg & pwrite;
  wire hit_flags = reg_hit(paddr, OFS_FLAGS);
  wire hit_en    = reg_hit(paddr, OFS_EN);
  wire hit_ccr   = reg_hit(paddr, OFS_CCR);
  wire hit_sp    = reg_hit(paddr, OFS_SP);
  wire hit_stat  = reg_hit(paddr, OFS_STAT);
  wire map_hit   = hit_flags | hit_en | hit_ccr | hit_sp | hit_stat;
  wire sw_ccr_wr = apb_wr & hit_ccr;
  wire sw_sp_wr  = apb_wr & hit_sp;

  // RQ2 local enables; radio flags all follow one shared bit
  generate
    for (genvar i = 0; i < FLAG_N; i++) begin : g_en
      if (i == F_RERR || i == F_RLOW) begin : g_shared
        assign en_eff[i] = en_reg[F_RSENT];
      end else begin : g_own
        assign en_eff[i] = en_reg[i];
      end
    end
  endgenerate

  // RQ25 flag ANDed with enable
  assign flag_req = flag_reg & en_eff;

  // RQ17 groups by priority; RQ18 spare pair tied off
  assign grp_req[P_KEYPIN] = flag_req[F_KEYPIN];
  assign grp_req[P_CMATCH] = flag_req[F_CMATCH];
  assign grp_req[P_SPARE]  = 1'b0;
  // RQ19 tick masked in stop, conversion at 10
  assign grp_req[P_TICK]   = flag_req[F_TICK] & ~stop_mode;
  assign grp_req[P_CONV]   = flag_req[F_CONV];
  // RQ20 four receiver flags merge
  assign grp_req[P_LOWFREQ] = |flag_req[F_LFBYTE:F_LFIDENT];
  // RQ21 three radio flags merge
  assign grp_req[P_RADIO]  = |flag_req[F_RLOW:F_RSENT];
  // Soft trap and reset are not flag driven
  assign grp_req[P_SOFT]   = 1'b0;
  assign grp_req[P_RESET]  = 1'b0;

  // RQ24 plain sources at priorities 8 down to 2
  generate
    for (genvar k = 0; k < SINGLE_N; k++) begin : g_single
      assign grp_req[P_SENSOR-k] = flag_req[F_SENSOR+k];
    end
  endgenerate

  // RQ15 fixed encoder picks the highest pending
  wire       any_req   = |grp_req;
  wire [3:0] enc_prio  = prio_pick(grp_req);
  // RQ2 mask gates what the CPU accepts
  wire       irq_qual  = any_req & ~ccr_reg[CCR_I_BIT];
  // RQ10 priority sampled at vector time, not at entry
  wire [3:0] vec_pick  = (hw_entry_reg && any_req) ? enc_prio : entry_prio_reg;

  // RQ6 stacking order by byte count
  wire [7:0] push_byte = (cnt_reg == 3'h0) ? pc_reg[7:0] :
                         (cnt_reg == 3'h1) ? pc_reg[15:8] :
                         (cnt_reg == 3'h2) ? x_reg :
                         (cnt_reg == 3'h3) ? acc_reg : ccr_reg;

  // Read mux; unmapped reads return zero with an error
  wire [31:0] stat_word = 32'({state_reg, vec_prio_reg, irq_qual, any_req, enc_prio});
  wire [31:0] rd_word   = hit_flags ? 32'(flag_reg) :
                          hit_en    ? 32'(en_reg) :
                          hit_ccr   ? 32'(ccr_reg) :
                          hit_sp    ? 32'(sp_reg) :
                          hit_stat  ? stat_word : 32'h0000_0000;

  // RQ1 hardware set beats a same-cycle software clear
  // RQ23 write-one-to-clear is the routine's acknowledge
  assign flag_next = (flag_reg & ~((apb_wr && hit_flags) ? pwdata[FLAG_N-1:0] : '0))
                   | src_event;
  assign en_next   = (apb_wr && hit_en) ? (pwdata[FLAG_N-1:0] & EN_MASK) : en_reg;

  // Flags and enables
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= '0;
      en_reg   <= '0;
    end else begin
      flag_reg <= flag_next;
      en_reg   <= en_next;
    end
  end

  // APB answer registered in the setup cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~map_hit;
      if (apb_setup) begin
        prdata_reg <= rd_word;
      end
    end
  end

  // RQ22 wake needs flag and enable (tick also needs stop off), not the mask
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg  <= irq_qual;
      wake_reg <= any_req;
    end
  end

  // Entry, vector, fill and return sequencer; one byte per access
  // RQ14 only X low is stacked, the high index byte is the routine's job
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // RQ3 mask set; reset vector fetch starts at once
      state_reg      <= S_VECT;
      cnt_reg        <= 3'h0;
      ph_reg         <= PH_SET;
      hw_entry_reg   <= 1'b0;
      entry_prio_reg <= P_RESET;
      vec_prio_reg   <= P_RESET;
      pc_reg         <= 16'h0000;
      sp_reg         <= SP_INIT;
      acc_reg        <= 8'h00;
      x_reg          <= 8'h00;
      ccr_reg        <= CCR_RESET;
      mem_req_reg    <= 1'b0;
      mem_we_reg     <= 1'b0;
      mem_addr_reg   <= 16'h0000;
      mem_wdata_reg  <= 8'h00;
      busy_reg       <= 1'b1;
      done_reg       <= 1'b0;
      qbyte_reg      <= 8'h00;
      qvalid_reg     <= 1'b0;
    end else begin
      mem_req_reg <= 1'b0;
      qvalid_reg  <= 1'b0;
      done_reg    <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (sw_ccr_wr) begin
            ccr_reg <= pwdata[7:0];
          end
          if (sw_sp_wr) begin
            sp_reg <= pwdata[15:0];
          end
          // RQ4 only between instructions; pending request goes first
          // RQ8 capture the address that would run next
          if (instr_boundary && (irq_qual || soft_trap)) begin
            // RQ5 hardware entry and soft trap share this path
            state_reg      <= S_PUSH;
            hw_entry_reg   <= irq_qual;
            entry_prio_reg <= irq_qual ? enc_prio : P_SOFT;
            pc_reg         <= cpu_next_pc;
            acc_reg        <= cpu_acc;
            x_reg          <= cpu_x;
            cnt_reg        <= 3'h0;
            ph_reg         <= PH_SET;
            busy_reg       <= 1'b1;
          end else if (instr_boundary && return_trap) begin
            state_reg <= S_POP;
            cnt_reg   <= 3'h0;
            ph_reg    <= PH_SET;
            busy_reg  <= 1'b1;
          end
        end
        S_PUSH: begin
          if (ph_reg == PH_SET) begin
            // RQ7 write at the free byte, then step down
            mem_req_reg   <= 1'b1;
            mem_we_reg    <= 1'b1;
            mem_addr_reg  <= sp_reg;
            mem_wdata_reg <= push_byte;
            sp_reg        <= sp_reg - 16'h0001;
            ph_reg        <= PH_BUS;
          end else begin
            ph_reg <= PH_SET;
            if (cnt_reg == PUSH_LAST) begin
              // RQ9 mask set after CONDITION_CODE_REG is safely stacked
              ccr_reg[CCR_I_BIT] <= 1'b1;
              state_reg          <= S_VECT;
              cnt_reg            <= 3'h0;
            end else begin
              cnt_reg <= cnt_reg + 3'h1;
            end
          end
        end
        S_VECT: begin
          if (ph_reg == PH_SET) begin
            mem_req_reg <= 1'b1;
            mem_we_reg  <= 1'b0;
            ph_reg      <= PH_BUS;
            // RQ16 high byte first, from the lower address
            if (cnt_reg == 3'h0) begin
              vec_prio_reg <= vec_pick;
              mem_addr_reg <= vec_addr(vec_pick);
            end else begin
              mem_addr_reg <= vec_addr(vec_prio_reg) + 16'h0001;
            end
          end else if (ph_reg == PH_BUS) begin
            ph_reg <= PH_DATA;
          end else begin
            ph_reg <= PH_SET;
            if (cnt_reg == VEC_LAST) begin
              pc_reg[7:0] <= mem_rdata;
              state_reg   <= S_FILL;
              cnt_reg     <= 3'h0;
            end else begin
              pc_reg[15:8] <= mem_rdata;
              cnt_reg      <= cnt_reg + 3'h1;
            end
          end
        end
        S_FILL: begin
          // RQ11 RQ13 three bytes from the new program address
          if (ph_reg == PH_SET) begin
            mem_req_reg  <= 1'b1;
            mem_we_reg   <= 1'b0;
            mem_addr_reg <= pc_reg + 16'(cnt_reg);
            ph_reg       <= PH_BUS;
          end else if (ph_reg == PH_BUS) begin
            ph_reg <= PH_DATA;
          end else begin
            ph_reg     <= PH_SET;
            qbyte_reg  <= mem_rdata;
            qvalid_reg <= 1'b1;
            if (cnt_reg == FILL_LAST) begin
              state_reg <= S_IDLE;
              busy_reg  <= 1'b0;
              done_reg  <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 3'h1;
            end
          end
        end
        S_POP: begin
          if (ph_reg == PH_SET) begin
            // Pre-increment undoes the push post-decrement
            mem_req_reg  <= 1'b1;
            mem_we_reg   <= 1'b0;
            mem_addr_reg <= sp_reg + 16'h0001;
            sp_reg       <= sp_reg + 16'h0001;
            ph_reg       <= PH_BUS;
          end else if (ph_reg == PH_BUS) begin
            ph_reg <= PH_DATA;
          end else begin
            ph_reg <= PH_SET;
            // RQ12 reverse of the stacking order
            unique case (cnt_reg)
              3'h0:    ccr_reg      <= mem_rdata;
              3'h1:    acc_reg      <= mem_rdata;
              3'h2:    x_reg        <= mem_rdata;
              3'h3:    pc_reg[15:8] <= mem_rdata;
              default: pc_reg[7:0]  <= mem_rdata;
            endcase
            if (cnt_reg == PUSH_LAST) begin
              state_reg <= S_FILL;
              cnt_reg   <= 3'h0;
            end else begin
              cnt_reg <= cnt_reg + 3'h1;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign mem_req            = mem_req_reg;
  assign mem_we             = mem_we_reg;
  assign mem_addr           = mem_addr_reg;
  assign mem_wdata          = mem_wdata_reg;
  assign seq_busy           = busy_reg;
  assign seq_done           = done_reg;
  assign queue_byte         = qbyte_reg;
  assign queue_valid        = qvalid_reg;
  assign resume_pc          = pc_reg;
  assign restored_acc       = acc_reg;
  assign restored_x         = x_reg;
  assign condition_code_reg = ccr_reg;
  assign irq_request        = irq_reg;
  assign wake_request       = wake_reg;

  // Helper: cycles since reset release, saturating
  logic [1:0] boot_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != 2'h3) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  flag_capture_a: assert property ((src_event != '0) |=> ((flag_reg & $past(src_event)) == $past(src_event))) // RQ1
    else $error("event did not set its flag");
  irq_gate_a: assert property (irq_request |-> ($past(any_req) && !$past(ccr_reg[CCR_I_BIT]))) // RQ2
    else $error("request raised while masked or idle");
  boot_mask_a: assert property ((boot_cnt != 2'h3) |-> ccr_reg[CCR_I_BIT]) // RQ3
    else $error("mask clear right after reset");
  entry_boundary_a: assert property ((state_reg == S_IDLE) ##1 (state_reg == S_PUSH) |-> $past(instr_boundary)) // RQ4
    else $error("entry started mid instruction");
  push_first_a: assert property ((state_reg == S_PUSH && cnt_reg == 3'h0 && ph_reg == PH_BUS) |-> (mem_we && mem_req && mem_wdata == pc_reg[7:0])) // RQ6
    else $error("first push is not PC low");
  sp_step_a: assert property ((state_reg == S_PUSH && ph_reg == PH_BUS) |-> (sp_reg == mem_addr - 16'h0001)) // RQ7
    else $error("stack pointer not one below write");
  vect_mask_a: assert property ((state_reg == S_VECT) |-> ccr_reg[CCR_I_BIT]) // RQ9
    else $error("vector fetched with mask clear");
  vec_addr_a: assert property ((state_reg == S_VECT && ph_reg == PH_BUS) |-> (!mem_we && mem_addr == vec_addr(vec_prio_reg) + 16'(cnt_reg))) // RQ16
    else $error("wrong vector byte address");
  spare_pair_a: assert property ((state_reg == S_VECT) |-> (vec_prio_reg != 4'(P_SPARE))) // RQ18
    else $error("spare vector pair fetched");
  fill_addr_a: assert property ((state_reg == S_FILL && ph_reg == PH_BUS) |-> (mem_addr == pc_reg + 16'(cnt_reg)) ##2 queue_valid) // RQ11
    else $error("queue fill address or byte missing");
  tick_stop_a: assert property (stop_mode |-> !grp_req[P_TICK]) // RQ19
    else $error("tick requested in stop");
  wake_a: assert property (any_req |=> wake_request) // RQ22
    else $error("pending request did not wake");

  cover_hw_entry: cover property ((state_reg == S_IDLE && instr_boundary && irq_qual) ##[1:40] seq_done);
  cover_soft_trap: cover property (instr_boundary && soft_trap && !irq_qual && state_reg == S_IDLE);
  cover_return: cover property ((state_reg == S_POP) ##[1:40] (state_reg == S_FILL));
  cover_set_clear: cover property (apb_wr && hit_flags && (src_event & pwdata[FLAG_N-1:0]) != '0);

endmodule

`default_nettype wire

// File: testbench/pis_mem_model.sv
// Byte memory behind the sequencer: stack, vector table and program
`timescale 1ns/1ps
`default_nettype none
module pis_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [65536];
  logic [7:0] rd_reg;
  logic       rd_ok_reg;
  // Pattern from address, so every vector pair points somewhere else
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h3C;
  end
  // Writes land on the request edge, reads answer one cycle later
  always @(posedge core_clk) begin
    if (mem_req && mem_we)
      mem[mem_addr] <= mem_wdata;
    if (mem_req && !mem_we)
      rd_reg <= mem[mem_addr];
    rd_ok_reg <= mem_req && !mem_we;
  end
  // Outside the answer cycle the bus shows junk, never the stale byte
  assign mem_rdata = rd_ok_reg ? rd_reg : ~rd_reg;
endmodule
`default_nettype wire

// File: testbench/prioritized_interrupt_sequencer_tb.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_sequencer_tb;
  import pis_pkg::*;
  localparam logic [15:0] SP0 = 16'h00FF;
  // Rows: flag bit n must enter through priority PRIO[n]
  localparam logic [3:0] PRIO [18] = '{4'hF, 4'hE, 4'hC, 4'hB, 4'hB, 4'hB, 4'hB, 4'hA,
    4'h9, 4'h9, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2};
  logic        core_clk, pready, pslverr, mem_req, mem_we, seq_busy, seq_done, err, queue_valid;
  logic        irq_request, wake_request, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        stop_mode = 0, instr_boundary = 0, soft_trap = 0, return_trap = 0;
  logic [7:0]  paddr = 0, cpu_acc = 0, cpu_x = 0, mem_wdata, mem_rdata;
  logic [7:0]  restored_acc, restored_x, condition_code_reg, queue_byte;
  logic [15:0] cpu_next_pc = 0, mem_addr, resume_pc;
  logic [17:0] src_event = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [24:0] log_q [$], exp_q [$];
  int          n_mismatch, compares;

  pis_sequencer #(.SP_INIT(SP0)) dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_event, .stop_mode, .instr_boundary,
    .soft_trap, .return_trap, .cpu_next_pc, .cpu_acc, .cpu_x, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .seq_busy, .seq_done, .queue_byte,
    .queue_valid, .resume_pc, .restored_acc, .restored_x, .condition_code_reg,
    .irq_request, .wake_request);
  pis_mem_model mem (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Log every memory access; read entries carry no data
  always @(posedge core_clk) begin
    if (mem_req === 1'b1)
      log_q.push_back({mem_we, mem_addr, mem_we ? mem_wdata : 8'h00});
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle edge so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic fire(input logic [17:0] m);
    src_event <= m;
    @(posedge core_clk);
    src_event <= 18'h0_0000;
    @(posedge core_clk);
  endtask
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction
  task automatic fill(input logic [15:0] t);
    for (int i = 0; i < 3; i++)
      exp_q.push_back({1'b0, t + 16'(i), 8'h00});
  endtask
  task automatic exp_entry(input logic [3:0] p);
    logic [15:0] v;
    logic [7:0]  s [5];
    v = 16'hFFE0 + 16'(2 * (15 - p));
    s = '{cpu_next_pc[7:0], cpu_next_pc[15:8], cpu_x, cpu_acc, condition_code_reg};
    exp_q.delete();
    for (int i = 0; i < 5; i++)
      exp_q.push_back({1'b1, SP0 - 16'(i), s[i]});
    exp_q.push_back({1'b0, v, 8'h00});
    exp_q.push_back({1'b0, v + 16'h0001, 8'h00});
    fill({m(v), m(v + 16'h0001)});
  endtask
  task automatic exp_ret();
    exp_q.delete();
    for (int i = 0; i < 5; i++)
      exp_q.push_back({1'b0, SP0 - 16'h0004 + 16'(i), 8'h00});
    fill(cpu_next_pc);
  endtask
  // Boundary pulse, wait for the sequence end, compare the access log
  task automatic step(input logic s, input logic r);
    log_q.delete();
    instr_boundary <= 1'b1;
    soft_trap <= s;
    return_trap <= r;
    @(posedge core_clk);
    instr_boundary <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (seq_done !== 1'b1);
    ck(log_q.size(), exp_q.size());
    ck({queue_valid, queue_byte}, {1'b1, m(exp_q[$][23:8])});
    foreach (exp_q[i])
      ck(log_q[i], exp_q[i]);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    ck(seq_busy, 1);
    ck(condition_code_reg, 8'h08);
    rstn <= 1'b1;
    while (seq_busy !== 1'b0) begin
      @(posedge core_clk);
    end
    apb(1'b0, OFS_CCR, 32'h0);
    ck(rd, 32'h0000_0008);
    for (int b = 0; b < 18; b++) begin
      cpu_next_pc <= 16'h1200 + 16'(b);
      cpu_acc <= 8'hA0 + 8'(b);
      cpu_x <= 8'h50 + 8'(b);
      apb(1'b1, OFS_EN, 32'h0000_0001 << ((b == 9 || b == 10) ? 8 : b));
      fire(18'h0_0001 << b);
      apb(1'b0, OFS_FLAGS, 32'h0);
      ck(rd, 32'h0000_0001 << b);
      ck(irq_request, 0);
      apb(1'b1, OFS_CCR, 32'h0);
      @(posedge core_clk);
      ck(irq_request, 1);
      exp_entry(PRIO[b]);
      step(1'b0, 1'b0);
      ck(condition_code_reg, 8'h08);
      apb(1'b1, OFS_FLAGS, 32'h0000_0001 << b);
      exp_ret();
      step(1'b0, 1'b1);
      ck({restored_acc, restored_x, condition_code_reg}, {cpu_acc, cpu_x, 8'h00});
      ck(resume_pc, cpu_next_pc);
      apb(1'b1, OFS_CCR, 32'h0000_0008);
      $display("row %0d done", b);
    end
    // Two sources wait under the mask; the higher one goes first
    apb(1'b1, OFS_EN, 32'h0003_FFFF);
    fire(18'h0_0081);
    apb(1'b1, OFS_CCR, 32'h0);
    exp_entry(4'hA);
    step(1'b0, 1'b0);
    apb(1'b1, OFS_FLAGS, 32'h0003_FFFF);
    exp_ret();
    step(1'b0, 1'b1);
    $display("pending order done");
    // Tick may not wake from stop, conversion must
    stop_mode <= 1'b1;
    fire(18'h0_0004);
    @(posedge core_clk);
    ck(wake_request, 0);
    stop_mode <= 1'b0;
    repeat (2) @(posedge core_clk);
    ck(wake_request, 1);
    stop_mode <= 1'b1;
    apb(1'b1, OFS_FLAGS, 32'h0000_0004);
    fire(18'h0_0080);
    @(posedge core_clk);
    ck(wake_request, 1);
    stop_mode <= 1'b0;
    apb(1'b1, OFS_FLAGS, 32'h0003_FFFF);
    $display("stop wake done");
    // Soft trap walks the same frame through its own vector
    exp_entry(P_SOFT);
    step(1'b1, 1'b0);
    exp_ret();
    step(1'b0, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    ck(err, 1);
    ck(rd, 32'h0);
    $display("soft trap and bus error done");
    // Mid-run reset while the mask is clear must set it again
    rstn <= 1'b0;
    @(posedge core_clk);
    ck(condition_code_reg, 8'h08);
    ck(seq_busy, 1);
    rstn <= 1'b1;
    while (seq_busy !== 1'b0) begin
      @(posedge core_clk);
    end
    $display("mid-run reset done");
    summarize();
  end
  // Cut a hang short: the whole run needs under 5000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
